// File: core/aft_frame_trigger.sv
// Frame start, serial gating and sample trigger control of the converter
`timescale 1ns/100ps
`default_nettype none
module aft_frame_trigger
    import aft_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic frame_sync_in,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic sample_trigger_n,
    input wire logic extended_mode,
    input wire logic sclk_conv_sel,
    input wire logic data_ready,
    input wire logic [AFT_WORD_W-1:0] tx_word,
    output logic serial_out,
    output logic serial_out_oe,
    output logic cycle_start,
    output logic sample_start,
    output logic hold_convert,
    output logic sampling,
    output logic conv_clk_tick,
    output logic [AFT_CNT_W-1:0] edge_count,
    output logic int_n,
    output logic [AFT_WORD_W-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready
);
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic cs_s, fs_s, sclk_s, sdi_s, trig_s;
    logic cs_fall, cs_rise, fs_rise, sclk_rise, sclk_fall;
    logic trig_fall, trig_rise;
    aft_state_t state;
    logic any_fall;
    logic [AFT_WORD_W-1:0] tx_shift;
    logic [AFT_WORD_W-1:0] rx_shift;
    logic [AFT_WORD_W-1:0] rx_word;
    logic rx_pending;
    logic buf_ready;
    logic start_now;
    logic last_fall;

    // Three flops per pin; only the second stage and its delayed copy are read
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync1 <= AFT_PIN_IDLE;
            sync2 <= AFT_PIN_IDLE;
            sync3 <= AFT_PIN_IDLE;
        end else begin
            sync1 <= {sample_trigger_n, serial_in, sclk, frame_sync_in, cs_n};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign cs_s = sync2[0];
    assign fs_s = sync2[1];
    assign sclk_s = sync2[2];
    assign sdi_s = sync2[3];
    assign trig_s = sync2[4];
    assign cs_fall = sync3[0] && !cs_s;
    assign cs_rise = !sync3[0] && cs_s;
    assign fs_rise = !sync3[1] && fs_s;
    assign sclk_rise = !sync3[2] && sclk_s;
    assign sclk_fall = sync3[2] && !sclk_s;
    assign trig_fall = sync3[4] && !trig_s;
    assign trig_rise = !sync3[4] && trig_s;

    // A cycle begins on chip select fall with sync high, or on a later sync rise
    assign start_now = (cs_fall && fs_s)
        || (!cs_rise && fs_rise && (state == AFT_WAIT_FS));
    assign last_fall = (state == AFT_ACTIVE) && sclk_fall
        && (edge_count == AFT_CNT_LAST);

    // Frame state; chip select rise always wins and ends the frame
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= AFT_IDLE;
        end else begin
            case (state)
                AFT_IDLE: begin
                    if (cs_fall) begin
                        state <= fs_s ? AFT_ACTIVE : AFT_WAIT_FS;
                    end
                end
                AFT_WAIT_FS: begin
                    if (cs_rise) begin
                        state <= AFT_IDLE;
                    end else if (fs_rise) begin
                        state <= AFT_ACTIVE;
                    end
                end
                AFT_ACTIVE: begin
                    if (cs_rise) begin
                        state <= AFT_IDLE;
                    end else if (last_fall) begin
                        state <= AFT_DONE;
                    end
                end
                AFT_DONE: begin
                    // A fresh sync rise restarts only once the word left
                    if (cs_rise) begin
                        state <= AFT_IDLE;
                    end else if (fs_rise && !rx_pending) begin
                        state <= AFT_ACTIVE;
                    end
                end
                default: begin
                    state <= AFT_IDLE;
                end
            endcase
        end
    end

    // Edge counter and the start strobe
    always_ff @(posedge core_clk) begin
        if (srst) begin
            edge_count <= AFT_CNT_RST;
            cycle_start <= 1'b0;
            any_fall <= 1'b0;
        end else begin
            cycle_start <= start_now
                || (state == AFT_DONE && fs_rise && !rx_pending && !cs_rise);
            if (cs_fall || start_now) begin
                edge_count <= AFT_CNT_RST;
                any_fall <= 1'b0;
            end else if (state == AFT_ACTIVE && sclk_fall) begin
                edge_count <= edge_count + 4'h1;
                any_fall <= 1'b1;
            end else if (state == AFT_DONE && fs_rise && !rx_pending) begin
                edge_count <= AFT_CNT_RST;
                any_fall <= 1'b0;
            end
        end
    end

    // Output driver: enabled from chip select fall until it rises again
    always_ff @(posedge core_clk) begin
        if (srst) begin
            serial_out_oe <= 1'b0;
        end else if (cs_rise) begin
            serial_out_oe <= 1'b0;
        end else if (cs_fall) begin
            serial_out_oe <= 1'b1;
        end
    end

    // Transmit shifter: MSB stands at start, next bit on each rise after a fall
    always_ff @(posedge core_clk) begin
        if (srst) begin
            serial_out <= 1'b0;
            tx_shift <= AFT_WORD_RST;
        end else if (cycle_start) begin
            serial_out <= tx_word[AFT_WORD_W-1];
            tx_shift <= {tx_word[AFT_WORD_W-2:0], 1'b0};
        end else if (state == AFT_ACTIVE && sclk_rise && any_fall) begin
            serial_out <= tx_shift[AFT_WORD_W-1];
            tx_shift <= {tx_shift[AFT_WORD_W-2:0], 1'b0};
        end
    end

    // Receive shifter latches on falls only while the frame is active
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_shift <= AFT_WORD_RST;
            rx_word <= AFT_WORD_RST;
            rx_pending <= 1'b0;
        end else begin
            if (state == AFT_ACTIVE && sclk_fall) begin
                rx_shift <= {rx_shift[AFT_WORD_W-2:0], sdi_s};
            end
            if (last_fall) begin
                rx_word <= {rx_shift[AFT_WORD_W-2:0], sdi_s};
                rx_pending <= 1'b1;
            end else if (rx_pending && buf_ready) begin
                rx_pending <= 1'b0;
            end
        end
    end

    // A stalled receiver holds the word here instead of dropping it
    aft_word_buf u_buf (
        .core_clk(core_clk),
        .srst(srst),
        .in_data(rx_word),
        .in_valid(rx_pending),
        .in_ready(buf_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // Sampling control; trigger ignores chip select, sync and shift clock
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sample_start <= 1'b0;
            hold_convert <= 1'b0;
            sampling <= 1'b0;
        end else begin
            sample_start <= extended_mode ? trig_fall
                : (last_fall ? 1'b0 : (state == AFT_ACTIVE && sclk_fall
                && edge_count == AFT_SAMPLE_EDGE));
            hold_convert <= extended_mode && trig_rise && sampling;
            if (!extended_mode) begin
                sampling <= 1'b0;
            end else if (trig_fall) begin
                sampling <= 1'b1;
            end else if (trig_rise) begin
                sampling <= 1'b0;
            end
        end
    end

    // Conversion tick from shift clock, independent of chip select
    always_ff @(posedge core_clk) begin
        if (srst) begin
            conv_clk_tick <= 1'b0;
        end else begin
            conv_clk_tick <= sclk_conv_sel && sclk_rise;
        end
    end

    // Interrupt: a new data ready wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            int_n <= 1'b1;
        end else if (data_ready) begin
            int_n <= 1'b0;
        end else if (cs_fall || fs_rise || trig_fall) begin
            int_n <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_hiz_on_cs_high;
        cs_rise |=> !serial_out_oe [*2];
    endproperty
    a_hiz_on_cs_high: assert property (p_hiz_on_cs_high) else
        $error("output driver stayed on after chip select rise");

    property p_cs_fall_clears;
        cs_fall |=> (edge_count == AFT_CNT_RST) && serial_out_oe;
    endproperty
    a_cs_fall_clears: assert property (p_cs_fall_clears) else
        $error("chip select fall did not clear counter or enable output");

    property p_spi_start;
        (state == AFT_IDLE) && cs_fall && fs_s |=>
            cycle_start && (state == AFT_ACTIVE);
    endproperty
    a_spi_start: assert property (p_spi_start) else
        $error("cycle did not start on chip select fall");

    property p_wait_sync;
        (state == AFT_IDLE) && cs_fall && !fs_s |=>
            !cycle_start && (state == AFT_WAIT_FS);
    endproperty
    a_wait_sync: assert property (p_wait_sync) else
        $error("cycle started without frame sync rise");

    property p_sync_start;
        (state == AFT_WAIT_FS) && fs_rise && !cs_rise |=>
            cycle_start && (edge_count == AFT_CNT_RST) ##1 serial_out_oe;
    endproperty
    a_sync_start: assert property (p_sync_start) else
        $error("frame sync rise did not start the cycle");

    property p_trig_sample;
        extended_mode && trig_fall |=> sample_start && sampling;
    endproperty
    a_trig_sample: assert property (p_trig_sample) else
        $error("trigger fall did not start sampling");

    property p_trig_hold;
        extended_mode && $past(extended_mode) && trig_rise && sampling
            |=> hold_convert && !sampling ##1 !hold_convert;
    endproperty
    a_trig_hold: assert property (p_trig_hold) else
        $error("trigger rise did not hold and convert");

    property p_sampling_level;
        sampling |-> !sync3[4] && extended_mode;
    endproperty
    a_sampling_level: assert property (p_sampling_level) else
        $error("sampling window differs from trigger low time");

    property p_ignore_after_done;
        (state == AFT_DONE) && !fs_rise |=> $stable(rx_shift);
    endproperty
    a_ignore_after_done: assert property (p_ignore_after_done) else
        $error("serial input taken after sixteen edges");

    property p_int_set;
        data_ready |=> !int_n;
    endproperty
    a_int_set: assert property (p_int_set) else
        $error("data ready did not drive interrupt low");

    property p_conv_tick;
        sclk_conv_sel && sclk_rise |=> conv_clk_tick ##1 !conv_clk_tick;
    endproperty
    a_conv_tick: assert property (p_conv_tick) else
        $error("shift clock did not reach conversion");

    property p_normal_sample;
        !extended_mode && (state == AFT_ACTIVE) && sclk_fall
            && (edge_count == AFT_SAMPLE_EDGE) |=> sample_start;
    endproperty
    a_normal_sample: assert property (p_normal_sample) else
        $error("normal sampling did not start after fourth clock");

    c_spi_frame: cover property (cycle_start && cs_s == 1'b0 ##[1:400]
        (state == AFT_DONE));
    c_sync_frame: cover property ((state == AFT_WAIT_FS) ##1
        (state == AFT_ACTIVE));
    c_ext_sample: cover property (sample_start && extended_mode ##[1:400]
        hold_convert);
    c_stall: cover property (rx_pending && !buf_ready);
endmodule
`default_nettype wire

// File: core/aft_pkg.sv
// Constants, types and behaviour summary of the frame and sample trigger block
// Behaviour
// - Chip select high: output tristated, input and shift clock ignored.
// - Selected shift clock feeds conversion even while chip select is high.
// - Chip select fall clears edge counter, enables input, clock, output.
// - Frame sync high at chip select fall: cycle starts at that fall.
// - Frame sync low at chip select fall: cycle starts at next sync rise.
// - Extended mode: trigger fall starts sampling the selected channel.
// - Extended mode: trigger rise puts hold on and starts conversion.
// - Sampling lasts while trigger stays low; host keeps it low enough.
// - Trigger acts regardless of shift clock, chip select and frame sync.
// - Frame sync start clears edge counter, enables input, output, clock.
// - Serial input ignored after sixteen counted edges or chip select rise.
// - Ready pulls interrupt low; select fall, sync rise, trigger fall clear.
// - Normal sampling starts automatically after the fourth shift clock.
package aft_pkg;
    localparam int AFT_WORD_W = 16;
    localparam int AFT_CNT_W = 4;
    localparam logic [AFT_CNT_W-1:0] AFT_CNT_RST = 4'h0;
    localparam logic [AFT_CNT_W-1:0] AFT_CNT_LAST = 4'hF;
    localparam logic [AFT_CNT_W-1:0] AFT_SAMPLE_EDGE = 4'h3;
    localparam logic [AFT_WORD_W-1:0] AFT_WORD_RST = 16'h0000;
    localparam int AFT_BUF_DEPTH = 2;
    // Pin idle levels {trigger, data, clock, sync, select} for the syncs
    localparam logic [4:0] AFT_PIN_IDLE = 5'h1B;

    typedef enum logic [3:0] {
        AFT_IDLE = 4'b0001,
        AFT_WAIT_FS = 4'b0010,
        AFT_ACTIVE = 4'b0100,
        AFT_DONE = 4'b1000
    } aft_state_t;
endpackage

// File: core/aft_word_buf.sv
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module aft_word_buf
    import aft_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [AFT_WORD_W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [AFT_WORD_W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [AFT_WORD_W-1:0] skid_data;
    logic skid_valid;
    logic push;
    logic head_free;

    // Head entry drives the outputs from flops; the skid entry catches
    // a word that arrives while the receiver stalls
    assign push = in_valid && in_ready;
    assign head_free = !out_valid || out_ready;
    assign in_ready = !skid_valid;

    // Head and skid entries; skid always drains into the head first
    always_ff @(posedge core_clk) begin
        if (srst) begin
            out_data <= AFT_WORD_RST;
            out_valid <= 1'b0;
            skid_data <= AFT_WORD_RST;
            skid_valid <= 1'b0;
        end else if (head_free) begin
            if (skid_valid) begin
                out_data <= skid_data;
                out_valid <= 1'b1;
                skid_valid <= 1'b0;
            end else begin
                out_valid <= push;
                if (push) begin
                    out_data <= in_data;
                end
            end
        end else if (push) begin
            skid_data <= in_data;
            skid_valid <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: dv/aft_host_model.sv
// Host serial port model driving the frame, shift clock and trigger pins
`timescale 1ns/100ps
`default_nettype none
module aft_host_model (
    input wire logic core_clk,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    output logic cs_n,
    output logic frame_sync_in,
    output logic sclk,
    output logic serial_in,
    output logic sample_trigger_n
);
    // Pins rest at the reset levels so release shows no false edge
    initial begin
        cs_n = 1'b1;
        frame_sync_in = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b1;
        sample_trigger_n = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Select; with sync low the device must wait for a sync rise
    task automatic cs_fall(input logic fs);
        frame_sync_in = fs;
        cs_n = 1'b0;
        wt(6);
    endtask

    task automatic fs_pulse();
        frame_sync_in = 1'b1;
        wt(4);
        frame_sync_in = 1'b0;
        wt(2);
    endtask

    // Four core cycles a half period; output sampled just before a fall
    task automatic shift(input logic [15:0] w, input int nb,
                         output logic [15:0] so);
        so = 16'hXXXX;
        for (int i = 0; i < nb; i++) begin
            serial_in = w[15-i];
            sclk = ~sclk;
            wt(4);
            so[15-i] = serial_out_oe ? serial_out : 1'bx;
            sclk = ~sclk;
            wt(4);
        end
    endtask

    // Released data line shows the inverse, never a stale bit
    task automatic release_cs();
        cs_n = 1'b1;
        serial_in = ~serial_in;
        wt(4);
        frame_sync_in = 1'b1;
        wt(4);
    endtask

    // Low time is the sampling window; high long enough to convert
    task automatic trig(input int low);
        sample_trigger_n = ~sample_trigger_n;
        wt(low);
        sample_trigger_n = ~sample_trigger_n;
        wt(20);
    endtask
endmodule
`default_nettype wire

// File: dv/aft_frame_trigger_tb.sv
// Self-checking bench for the frame and sample trigger block
`timescale 1ns/100ps
`default_nettype none
module aft_frame_trigger_tb;
    import aft_pkg::*;
    logic core_clk, srst, cs_n, frame_sync_in, sclk, serial_in;
    logic sample_trigger_n, extended_mode, sclk_conv_sel, data_ready;
    logic serial_out, serial_out_oe, cycle_start, sample_start;
    logic hold_convert, sampling, conv_clk_tick, int_n, rx_valid, rx_ready;
    logic [AFT_WORD_W-1:0] tx_word, rx_data;
    logic [AFT_CNT_W-1:0] edge_count;
    logic [15:0] exp_q[$];
    int n_errors = 0;
    int total_checks = 0;
    int n_cs, n_ss, n_hc, n_sp, n_ck;

    aft_frame_trigger u_dut (
        .core_clk(core_clk), .srst(srst), .cs_n(cs_n),
        .frame_sync_in(frame_sync_in), .sclk(sclk), .serial_in(serial_in),
        .sample_trigger_n(sample_trigger_n), .extended_mode(extended_mode),
        .sclk_conv_sel(sclk_conv_sel), .data_ready(data_ready),
        .tx_word(tx_word), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .cycle_start(cycle_start),
        .sample_start(sample_start), .hold_convert(hold_convert),
        .sampling(sampling), .conv_clk_tick(conv_clk_tick),
        .edge_count(edge_count), .int_n(int_n), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready)
    );

    aft_host_model u_host (
        .core_clk(core_clk), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .cs_n(cs_n),
        .frame_sync_in(frame_sync_in), .sclk(sclk),
        .serial_in(serial_in), .sample_trigger_n(sample_trigger_n)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Pulse and window tallies; old values at the edge are the real ones
    always @(posedge core_clk) begin
        if (srst) begin
            n_cs <= 0;
            n_ss <= 0;
            n_hc <= 0;
            n_sp <= 0;
            n_ck <= 0;
        end else begin
            n_cs <= n_cs + cycle_start;
            n_ss <= n_ss + sample_start;
            n_hc <= n_hc + hold_convert;
            n_sp <= n_sp + sampling;
            n_ck <= n_ck + conv_clk_tick;
        end
    end

    // Each accepted word is matched against the oldest noted word
    always @(posedge core_clk) begin
        if (!srst && rx_valid === 1'b1 && rx_ready) begin
            if (exp_q.size() == 0) begin
                chk("rx_unexpected", 0, 1);
            end else begin
                chk("rx_data", exp_q.pop_front(), rx_data);
            end
        end
    end

    // One frame; partial frames are left selected for the caller
    task automatic frame(input logic fsm, input int nb);
        logic [15:0] w;
        logic [15:0] so;
        int c0;
        int s0;
        w = 16'($urandom);
        tx_word = 16'($urandom);
        c0 = n_cs;
        s0 = n_ss;
        u_host.cs_fall(!fsm);
        if (fsm) begin
            chk("early_start", c0, n_cs);
            u_host.fs_pulse();
        end
        chk("cycle_start", c0 + 1, n_cs);
        chk("edge_count", 0, edge_count);
        if (nb == 16) exp_q.push_back(w);
        u_host.shift(w, nb, so);
        chk("serial_out", tx_word >> (16 - nb), so >> (16 - nb));
        if (!extended_mode) chk("auto_sample", s0 + 1, n_ss);
        if (nb < 16) begin
            chk("edge_count", nb, edge_count);
        end else begin
            u_host.release_cs();
            chk("oe_off", 0, serial_out_oe);
        end
    endtask

    initial begin
        logic [15:0] so;
        int h0;
        int s0;
        int p0;
        srst = 1'b1;
        extended_mode = 1'b0;
        sclk_conv_sel = 1'b0;
        data_ready = 1'b0;
        tx_word = 16'h0000;
        rx_ready = 1'b1;
        void'($urandom(32'h0A62));
        repeat (5) @(negedge core_clk);
        srst = 1'b0;
        u_host.wt(2);
        chk("oe_reset", 0, serial_out_oe);
        chk("int_reset", 1, int_n);
        for (int k = 0; k < 4; k++) frame(k[0], 16);
        // Normal mode ignores the trigger; extended acts with cs high or low
        for (int k = 0; k < 3; k++) begin
            extended_mode = (k != 0);
            if (k == 2) frame(1'b0, 12);
            h0 = n_hc;
            s0 = n_ss;
            p0 = n_sp;
            u_host.trig(5 + 7 * k);
            chk("hold", h0 + (k != 0), n_hc);
            chk("trig_sample", s0 + (k != 0), n_ss);
            chk("window", (k != 0) ? 5 + 7 * k : 0, n_sp - p0);
            if (k == 2) u_host.release_cs();
        end
        // Stall the receiver past the two entries, then drain
        extended_mode = 1'b0;
        rx_ready = 1'b0;
        for (int k = 0; k < 3; k++) frame(1'($urandom), 16);
        chk("stall_valid", 1, rx_valid);
        chk("stall_kept", 3, exp_q.size());
        repeat (12) begin
            u_host.wt(1);
            rx_ready = 1'($urandom);
        end
        rx_ready = 1'b1;
        u_host.wt(10);
        chk("drained", 0, exp_q.size());
        chk("empty", 0, rx_valid);
        // Ready flag cleared once by a trigger fall, once by a select fall
        extended_mode = 1'b1;
        for (int k = 0; k < 2; k++) begin
            data_ready = ~data_ready;
            u_host.wt(1);
            data_ready = ~data_ready;
            u_host.wt(2);
            chk("int_set", 0, int_n);
            if (k == 0) u_host.trig(5);
            else u_host.cs_fall(1'b1);
            chk("int_clr", 1, int_n);
            if (k == 1) u_host.release_cs();
        end
        // Ready pulse in the very cycle a synced trigger fall clears it
        fork
            u_host.trig(5);
            begin
                u_host.wt(2);
                data_ready = ~data_ready;
                u_host.wt(1);
                data_ready = ~data_ready;
            end
        join
        chk("int_set_wins", 0, int_n);
        // Shift clock with cs high moves no data but may clock conversion
        for (int k = 0; k < 2; k++) begin
            sclk_conv_sel = k[0];
            h0 = n_ck;
            s0 = n_cs;
            u_host.shift(16'hA5A5, 6, so);
            chk("conv_tick", 6 * k, n_ck - h0);
            chk("no_frame", s0, n_cs);
        end
        // Mid-run reset with the ready flag low and all pins idle
        data_ready = ~data_ready;
        u_host.wt(1);
        data_ready = ~data_ready;
        chk("int_pre", 0, int_n);
        srst = 1'b1;
        u_host.wt(3);
        srst = 1'b0;
        u_host.wt(2);
        chk("int_rerun", 1, int_n);
        chk("oe_rerun", 0, serial_out_oe);
        chk("count_rerun", 0, edge_count);
        chk("valid_rerun", 0, rx_valid);
        tally_and_finish();
    end

    initial begin
        repeat (30000) @(posedge core_clk);
        n_errors++;
        $display("[ERR] watchdog expected end seen hang");
        tally_and_finish();
    end
endmodule
`default_nettype wire
